// ### hdl/seci_pkg.sv
package seci_pkg;

    localparam int          SECI_ADDR_W       = 8;
    localparam int          SECI_DATA_W       = 16;
    localparam int          SECI_WORDS        = 256;
    localparam int          SECI_PAGE_WORDS   = 4;
    localparam int          SECI_PROG_CNT_W   = 18;

    // Programming time and the clock rate it is counted in
    localparam int          SECI_PROG_TIME_MS = 10;
    localparam int          SECI_MCLK_HZ      = 25_000_000;
    localparam int          SECI_PROG_CYCLES  =
        SECI_PROG_TIME_MS * (SECI_MCLK_HZ / 1000);

    // Bit counter positions of the last bit of each field
    localparam logic [4:0]  SECI_LAST_CMD_BIT  = 5'h09;
    localparam logic [4:0]  SECI_LAST_DATA_BIT = 5'h0f;

    localparam logic [1:0]  SECI_OP_READ  = 2'h2;
    localparam logic [1:0]  SECI_OP_WRITE = 2'h1;
    localparam logic [1:0]  SECI_OP_PAGE  = 2'h3;
    localparam logic [1:0]  SECI_OP_MISC  = 2'h0;

    // Address bits 7:6 of op-code 00, then full addresses of boundary clear and freeze
    localparam logic [1:0]  SECI_MISC_FILL   = 2'h1;
    localparam logic [1:0]  SECI_MISC_ENABLE = 2'h3;
    localparam logic [1:0]  SECI_MISC_LOCK   = 2'h0;
    localparam logic [7:0]  SECI_BCLEAR_ADDR = 8'hff;
    localparam logic [7:0]  SECI_BFREEZE_ADDR = 8'h00;

    // Values after reset
    localparam logic [7:0]  SECI_PROT_RST      = 8'hff;
    localparam logic        SECI_PROT_FLAG_RST = 1'b1;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_CMD  = 3'h1,
        S_DATA = 3'h3,
        S_HOLD = 3'h2,
        S_READ = 3'h6
    } seci_state_t;

    typedef enum logic [2:0] {
        P_NONE    = 3'h0,
        P_WORD    = 3'h1,
        P_PAGE    = 3'h2,
        P_FILL    = 3'h3,
        P_BWRITE  = 3'h4,
        P_BCLEAR  = 3'h5,
        P_BFREEZE = 3'h6
    } seci_pend_t;

    typedef struct packed {
        seci_state_t                  state;
        seci_pend_t                   pend;
        logic                         sclkPrev;
        logic                         csPrev;
        logic [4:0]                   bitCnt;
        logic [8:0]                   cmdSr;
        logic [7:0]                   addr;
        logic [15:0]                  dataSr;
        logic [15:0]                  outSr;
        logic                         boundaryRd;
        logic                         pendReady;
        logic [1:0]                   pageSlot;
        logic [3:0]                   slotMask;
        logic [3:0][15:0]             pageBuf;
        logic                         weLatch;
        logic                         unlockArm;
        logic [7:0]                   protReg;
        logic                         protFlag;
        logic                         otp;
        logic                         busy;
        logic [SECI_PROG_CNT_W-1:0]   progCnt;
        logic                         fillActive;
        logic [7:0]                   fillAddr;
        logic                         statusMode;
        logic                         dout;
        logic                         doutEn;
    } seci_core_t;

endpackage

// ### hdl/seci_pin_sync.sv
`timescale 1ns/10ps
module seci_pin_sync (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic [4:0] pinIn,
    output logic      [4:0] pinOut
);
    typedef struct packed {
        logic [4:0] meta;
        logic [4:0] stable;
    } seci_sync_t;

    seci_sync_t r;
    seci_sync_t n;

    always_comb begin
        n.meta   = pinIn;
        n.stable = r.meta;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign pinOut = r.stable;
endmodule

// ### hdl/seci_core.sv
`timescale 1ns/10ps
// Notes on behaviour
// (R01) Instruction is start bit, two-bit op-code, eight-bit address.
// (R02) With select high, zeros on data-in are skipped until a one.
// (R03) Reset clears programming state and leaves writes disabled.
// (R04) Read sends a dummy zero, then the 16-bit word MSB first.
// (R05) Output changes and input sampling both happen on clock rise.
// (R06) Select held high streams following words without a dummy bit.
// (R07) Protect pin low: 10 read, 01 word write, 11 page write.
// (R08) Protect pin low, op 00: 01xx fill, 11xx enable, 00xx disable.
// (R09) Protect pin high selects the five boundary instructions.
// (R10) Boundary read gives register plus flag; clear sets flag to one.
// (R11) Host holds write-enable pin high for modifying instructions.
// (R12) Writes stay permitted from enable until disable or reset.
// (R13) Memory read works whether writes are enabled or not.
// (R14) Host should disable writes after each programming cycle.
// (R15) Select falls after last data bit; protected addresses skip it.
// (R16) Busy drives output low with select high; ready drives high.
// (R17) Page write takes up to four words, wrapping low address bits.
// (R18) Select fall starts page write; any protected word skips page.
// (R19) Fill writes every word, only while the boundary is cleared.
// (R20) Programming cycle lasts at most 10 ms.
// (R21) Host serial clock at most 1 MHz, phases at least 250 ns; the test host uses 240 ns phases.
// (R22) Host keeps select low at least 250 ns between instructions.
// (R23) Any serial clock rate down to static keeps its state.
// (R24) Sequential read address wraps from top back to zero.
// (R25) Protected area is every address at or above the boundary.
// (R26) Host issues boundary_unlock right before each boundary change.
// (R27) Ready stays high until a start bit or select falls.
// (R28) Modifying instructions while writes disabled are dropped.
// (R29) Select low releases output and drops any partial instruction.
module seci_core #(
    parameter int unsigned PROG_CYCLES = seci_pkg::SECI_PROG_CYCLES
) (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic csPin,
    input  wire logic sclkPin,
    input  wire logic dataInPin,
    input  wire logic protEnPin,
    input  wire logic wrEnPin,
    output logic      dataOut,
    output logic      dataOutEn,
    output logic      progBusy,
    output logic      writeEnabled
);
    import seci_pkg::*;
    logic [15:0]  mem [SECI_WORDS];
    logic [4:0]   pinS;
    seci_core_t   r;
    seci_core_t   n;
    logic         csS;
    logic         sclkS;
    logic         dinS;
    logic         preS;
    logic         wS;
    logic         sclkRise;
    logic         csFall;
    logic         startProg;
    logic         memWordGo;
    logic         decRead;
    logic         decLock;
    logic [9:0]   cmd;
    logic [7:0]   nextAddr;
    logic         slotsProt;
    logic         bndOk;
    function automatic logic isProt(input logic [7:0] a,
                                    input logic [7:0] bound,
                                    input logic       cleared);
        isProt = !cleared && (a >= bound); // R25
    endfunction

    // Pins arrive from another clock, so all pass two flops first
    seci_pin_sync u_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .pinIn  ({csPin, sclkPin, dataInPin, protEnPin, wrEnPin}),
        .pinOut (pinS)
    );

    assign {csS, sclkS, dinS, preS, wS} = pinS;
    assign cmd      = {r.cmdSr, dinS};
    assign nextAddr = r.addr + 8'h01; // R24
    assign bndOk    = r.weLatch && wS && r.unlockArm && !r.otp; // R26
    always_comb begin
        slotsProt = 1'b0;
        for (int i = 0; i < SECI_PAGE_WORDS; i++) begin
            if (r.slotMask[i] &&
                isProt({r.addr[7:2], 2'(i)}, r.protReg, r.protFlag)) begin
                slotsProt = 1'b1; // R18
            end
        end
    end

    always_comb begin
        n          = r;
        startProg  = 1'b0;
        memWordGo  = 1'b0;
        decRead    = 1'b0;
        decLock    = 1'b0;
        sclkRise   = sclkS & ~r.sclkPrev; // R05
        csFall     = ~csS & r.csPrev;
        n.sclkPrev = sclkS;
        n.csPrev   = csS;

        if (r.busy) begin
            n.fillAddr   = r.fillAddr + 8'h01;
            n.fillActive = r.fillActive && (r.fillAddr != 8'hff);
            n.busy       = (r.progCnt != '0); // R20
            n.progCnt    = r.progCnt - 1'b1;
        end

        if (!csS) begin
            n.state     = S_IDLE; // R29
            n.doutEn    = 1'b0;
            n.dout      = 1'b0;
            n.pend      = P_NONE;
            n.pendReady = 1'b0;
            if (!r.busy) begin
                n.statusMode = 1'b0; // R27
            end
            // Execution only on a clean edge after a whole instruction
            if (csFall && r.pendReady && !r.busy) begin // R15
                unique case (r.pend)
                    P_WORD, P_PAGE: begin
                        if (!slotsProt) begin // R18
                            startProg = 1'b1;
                            memWordGo = 1'b1;
                        end
                    end
                    P_FILL: begin
                        if (r.protFlag) begin // R19
                            startProg    = 1'b1;
                            n.fillActive = 1'b1;
                            n.fillAddr   = 8'h00;
                        end
                    end
                    P_BWRITE: begin
                        startProg  = 1'b1;
                        n.protReg  = r.addr;
                        n.protFlag = 1'b0;
                    end
                    P_BCLEAR: begin
                        startProg  = 1'b1;
                        n.protReg  = SECI_PROT_RST;
                        n.protFlag = 1'b1; // R10
                    end
                    P_BFREEZE: begin
                        startProg = 1'b1;
                        n.otp     = 1'b1;
                    end
                    default: ;
                endcase
            end
            if (startProg) begin
                n.busy       = 1'b1;
                n.progCnt    = SECI_PROG_CNT_W'(PROG_CYCLES - 1);
                n.statusMode = 1'b1;
            end
        end else if (r.busy) begin
            n.doutEn = 1'b1; // R16
            n.dout   = 1'b0;
        end else if (r.statusMode) begin
            n.doutEn = 1'b1; // R16
            n.dout   = 1'b1;
            if (sclkRise && dinS) begin
                n.statusMode = 1'b0; // R27
                n.doutEn     = 1'b0;
                n.dout       = 1'b0;
                n.state      = S_CMD;
                n.bitCnt     = 5'h00;
            end
        end else if (sclkRise) begin
            unique case (r.state)
                S_IDLE: begin
                    if (dinS) begin
                        n.state  = S_CMD; // R02
                        n.bitCnt = 5'h00;
                    end
                end
                S_CMD: begin
                    n.cmdSr  = cmd[8:0];
                    n.bitCnt = r.bitCnt + 5'h01;
                    if (r.bitCnt == SECI_LAST_CMD_BIT) begin // R01
                        n.bitCnt    = 5'h00;
                        n.addr      = cmd[7:0];
                        n.pageSlot  = cmd[1:0];
                        n.slotMask  = 4'h0;
                        n.unlockArm = 1'b0; // R26
                        n.pend      = P_NONE;
                        n.pendReady = 1'b0;
                        n.state     = S_HOLD;
                        if (!preS) begin
                            unique case (cmd[9:8])
                                SECI_OP_READ: begin
                                    decRead      = 1'b1; // R13
                                    n.outSr      = mem[cmd[7:0]];
                                    n.boundaryRd = 1'b0;
                                    n.dout       = 1'b0; // R04
                                    n.doutEn     = 1'b1;
                                    n.state      = S_READ;
                                end
                                SECI_OP_WRITE, SECI_OP_PAGE: begin // R07
                                    n.state = S_DATA;
                                    if (r.weLatch && wS) begin // R28
                                        n.pend = (cmd[9:8] == SECI_OP_PAGE) ?
                                                 P_PAGE : P_WORD;
                                    end
                                end
                                SECI_OP_MISC: begin // R08
                                    if (cmd[7:6] == SECI_MISC_FILL) begin
                                        n.state = S_DATA;
                                        if (r.weLatch && wS) begin
                                            n.pend = P_FILL;
                                        end
                                    end else if (cmd[7:6] ==
                                                 SECI_MISC_ENABLE) begin
                                        n.weLatch = wS; // R12
                                    end else if (cmd[7:6] ==
                                                 SECI_MISC_LOCK) begin
                                        n.weLatch = 1'b0;
                                        decLock   = 1'b1;
                                    end
                                end
                            endcase
                        end else begin
                            unique case (cmd[9:8]) // R09
                                SECI_OP_READ: begin
                                    n.outSr = {r.protReg, r.protFlag,
                                               7'h00}; // R10
                                    n.boundaryRd = 1'b1;
                                    n.dout       = 1'b0;
                                    n.doutEn     = 1'b1;
                                    n.state      = S_READ;
                                end
                                SECI_OP_WRITE: begin
                                    if (bndOk) begin
                                        n.pend      = P_BWRITE;
                                        n.pendReady = 1'b1;
                                    end
                                end
                                SECI_OP_PAGE: begin
                                    if (bndOk &&
                                        cmd[7:0] == SECI_BCLEAR_ADDR) begin
                                        n.pend      = P_BCLEAR;
                                        n.pendReady = 1'b1;
                                    end
                                end
                                SECI_OP_MISC: begin
                                    if (cmd[7:6] == SECI_MISC_ENABLE) begin
                                        n.unlockArm = r.weLatch && wS;
                                    end else if (bndOk &&
                                                 cmd[7:0] ==
                                                 SECI_BFREEZE_ADDR) begin
                                        n.pend      = P_BFREEZE;
                                        n.pendReady = 1'b1;
                                    end
                                end
                            endcase
                        end
                    end
                end
                S_DATA: begin
                    n.dataSr    = {r.dataSr[14:0], dinS};
                    n.bitCnt    = r.bitCnt + 5'h01;
                    n.pendReady = 1'b0;
                    if (r.bitCnt == SECI_LAST_DATA_BIT) begin
                        n.bitCnt                = 5'h00;
                        n.pageBuf[r.pageSlot]   = {r.dataSr[14:0], dinS};
                        n.slotMask[r.pageSlot]  = 1'b1;
                        n.pageSlot              = r.pageSlot + 2'h1; // R17
                        n.pendReady             = (r.pend != P_NONE);
                        if (r.pend != P_PAGE) begin
                            n.state = S_HOLD;
                        end
                    end
                end
                S_HOLD: begin
                    // An extra clock after the last bit cancels the write
                    n.pendReady = 1'b0; // R15
                end
                S_READ: begin
                    n.dout = r.outSr[15]; // R05
                    if (r.bitCnt == SECI_LAST_DATA_BIT && !r.boundaryRd) begin
                        n.outSr  = mem[nextAddr]; // R06
                        n.addr   = nextAddr;
                        n.bitCnt = 5'h00;
                    end else begin
                        n.outSr  = {r.outSr[14:0], 1'b0};
                        n.bitCnt = r.bitCnt + 5'h01;
                    end
                end
            endcase
        end
    end

    // Static serial clock simply produces no edges, so state is held
    always_ff @(posedge mclk) begin // R23
        if (!resetn) begin
            r          <= '0; // R03
            r.protReg  <= SECI_PROT_RST;
            r.protFlag <= SECI_PROT_FLAG_RST;
        end else begin
            r <= n;
        end
    end

    // Array content is nonvolatile and deliberately not reset
    always_ff @(posedge mclk) begin
        if (memWordGo) begin
            for (int i = 0; i < SECI_PAGE_WORDS; i++) begin
                if (r.slotMask[i]) begin
                    mem[{r.addr[7:2], 2'(i)}] <= r.pageBuf[i]; // R17
                end
            end
        end
        if (r.fillActive) begin
            mem[r.fillAddr] <= r.dataSr; // R19
        end
    end

    assign dataOut      = r.dout;
    assign dataOutEn    = r.doutEn;
    assign progBusy     = r.busy;
    assign writeEnabled = r.weLatch;
    int unsigned busyLen;
    always_ff @(posedge mclk) begin
        if (!resetn || !r.busy) begin
            busyLen <= 0;
        end else begin
            busyLen <= busyLen + 1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    chk_sel_low_hiz: assert property (!csS |=> !r.doutEn) // R29
        else $error("output driven with select low");
    chk_busy_drives_low: assert property ( // R16
        r.busy && csS |=> r.doutEn && !r.dout)
        else $error("busy not shown as low");
    chk_prog_time: assert property (r.busy |-> busyLen < PROG_CYCLES) // R20
        else $error("programming cycle too long");
    chk_lock_clears: assert property (decLock |=> !r.weLatch) // R12
        else $error("disable did not clear write enable");
    chk_read_dummy: assert property ( // R04
        decRead |=> r.doutEn && !r.dout && r.state == S_READ)
        else $error("read did not start with dummy zero");
    chk_prog_needs_we: assert property (startProg |-> r.weLatch) // R28
        else $error("programming while writes disabled");
    chk_fill_gate: assert property ( // R19
        startProg && r.pend == P_FILL |-> r.protFlag)
        else $error("fill started with boundary set");
    chk_page_skip: assert property (memWordGo |-> !slotsProt) // R18
        else $error("protected word written");
    chk_out_on_rise: assert property ( // R05
        r.state == S_READ && csS && !sclkRise && !r.busy |=> $stable(r.dout))
        else $error("output moved without clock rise");
    chk_seq_addr: assert property ( // R06
        r.state == S_READ && csS && sclkRise && !r.boundaryRd &&
        r.bitCnt == SECI_LAST_DATA_BIT
        |=> r.addr == 8'($past(r.addr) + 8'h01))
        else $error("sequential address did not advance");

    cov_read: cover property (decRead);
    cov_word_prog: cover property (memWordGo);
    cov_fill: cover property (startProg && r.pend == P_FILL);
    cov_ready: cover property (r.statusMode && !r.busy && csS);
endmodule

// ### sim/seci_host.sv
`timescale 1ns/10ps
module seci_host (
    input  wire logic mclk,
    output logic      csPin,
    output logic      sclkPin,
    output logic      dataInPin,
    output logic      protEnPin,
    output logic      wrEnPin,
    input  wire logic dataOut,
    input  wire logic dataOutEn
);
    logic wireQ;

    // Released output reads as floating, never as a stale bit
    assign wireQ = dataOutEn ? dataOut : 1'bz;

    initial begin
        csPin     = 1'b0;
        sclkPin   = 1'b0;
        dataInPin = 1'b0;
        protEnPin = 1'b0;
        wrEnPin   = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Six mclk a phase gives 240 ns phases, which is faster than the allowed clock rate
    task automatic shift(input logic [15:0] v, input int n,
                         output logic [15:0] q);
        q = 16'h0000;
        for (int i = n - 1; i >= 0; i--) begin
            dataInPin = v[i];
            tick(6);
            sclkPin = 1'b1;
            tick(6);
            q = {q[14:0], wireQ};
            sclkPin = 1'b0;
        end
    endtask

    // Two leading zeros exercise the start-bit search
    task automatic start(input logic pre, input logic we,
                         input logic [1:0] op, input logic [7:0] addr,
                         output logic dummy);
        logic [15:0] q;
        protEnPin = pre;
        wrEnPin   = we;
        csPin     = 1'b1;
        tick(4);
        shift({3'h1, op, addr}, 13, q);
        dummy = q[0];
    endtask

    task automatic stop();
        csPin = 1'b0;
        tick(8);
    endtask

    task automatic peek(output logic q);
        csPin = 1'b1;
        tick(6);
        q = wireQ;
    endtask
endmodule

// ### sim/seci_core_tb_top.sv
`timescale 1ns/10ps
module seci_core_tb_top;
    import seci_pkg::*;
    localparam int PROG = 300;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic csPin, sclkPin, dataInPin, protEnPin, wrEnPin;
    logic dataOut, dataOutEn, progBusy, writeEnabled;
    logic d;
    int error_cnt = 0;
    int n_tests = 0;

    always #20 mclk = ~mclk;

    seci_core #(.PROG_CYCLES(PROG)) u_seci_core (
        .mclk(mclk), .resetn(resetn), .csPin(csPin), .sclkPin(sclkPin),
        .dataInPin(dataInPin), .protEnPin(protEnPin), .wrEnPin(wrEnPin),
        .dataOut(dataOut), .dataOutEn(dataOutEn), .progBusy(progBusy),
        .writeEnabled(writeEnabled));

    seci_host u_seci_host (
        .mclk(mclk), .csPin(csPin), .sclkPin(sclkPin),
        .dataInPin(dataInPin), .protEnPin(protEnPin), .wrEnPin(wrEnPin),
        .dataOut(dataOut), .dataOutEn(dataOutEn));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wait_ready();
        for (int i = 0; i < PROG + 20 && progBusy !== 1'b0; i++)
            @(posedge mclk);
        #1;
        chk(progBusy, 1'b0);
    endtask

    task automatic cmd(input logic pre, input logic [1:0] op,
                       input logic [7:0] addr);
        u_seci_host.start(pre, 1'b1, op, addr, d);
        u_seci_host.stop();
    endtask

    task automatic prog(input logic [1:0] op, input logic [7:0] addr,
                        input logic [3:0][15:0] w, input int n,
                        input logic expBusy);
        logic [15:0] q;
        u_seci_host.start(1'b0, 1'b1, op, addr, d);
        for (int k = 0; k < n; k++)
            u_seci_host.shift(w[k], 16, q);
        u_seci_host.stop();
        chk(progBusy, expBusy);
        if (expBusy) begin
            u_seci_host.peek(d);
            chk(d, 1'b0);
            wait_ready();
            u_seci_host.tick(4);
            chk(u_seci_host.wireQ, 1'b1);
            u_seci_host.stop();
        end
    endtask

    // Read runs with the write-enable pin low on purpose
    task automatic rd(input logic [7:0] addr, input logic [4:0][15:0] e,
                      input int n);
        logic [15:0] q;
        u_seci_host.start(1'b0, 1'b0, SECI_OP_READ, addr, d);
        chk(d, 1'b0);
        for (int k = 0; k < n; k++) begin
            u_seci_host.shift(16'h0000, 16, q);
            chk(q, e[k]);
        end
        u_seci_host.stop();
    endtask

    task automatic t_locked();
        prog(SECI_OP_WRITE, 8'h10, 64'h0, 1, 1'b0);
        cmd(1'b0, SECI_OP_MISC, 8'hc0);
        chk(writeEnabled, 1'b1);
        $display("t_locked done");
    endtask

    task automatic t_stream();
        prog(SECI_OP_WRITE, 8'h10, 64'ha5c3, 1, 1'b1);
        prog(SECI_OP_PAGE, 8'hfe, 64'h4d4d_3c3c_2b2b_1a1a, 4, 1'b1);
        prog(SECI_OP_WRITE, 8'h00, 64'he7e7, 1, 1'b1);
        rd(8'hfc, 80'he7e7_2b2b_1a1a_4d4d_3c3c, 5);
        $display("t_stream done");
    endtask

    task automatic t_bound();
        logic [15:0] q;
        cmd(1'b1, SECI_OP_MISC, 8'hc0);
        cmd(1'b1, SECI_OP_WRITE, 8'h80);
        wait_ready();
        u_seci_host.start(1'b1, 1'b0, SECI_OP_READ, 8'h00, d);
        chk(d, 1'b0);
        u_seci_host.shift(16'h0000, 9, q);
        chk(q, 16'h0100);
        u_seci_host.stop();
        prog(SECI_OP_WRITE, 8'h90, 64'h0, 1, 1'b0);
        cmd(1'b0, SECI_OP_MISC, 8'h00);
        chk(writeEnabled, 1'b0);
        rd(8'h10, 80'ha5c3, 1);
        $display("t_bound done");
    endtask

    // Clear boundary, fill, read back across the wrap, then freeze it
    task automatic t_fill();
        logic [15:0] q;
        cmd(1'b0, SECI_OP_MISC, 8'hc0);
        cmd(1'b1, SECI_OP_MISC, 8'hc0);
        cmd(1'b1, SECI_OP_PAGE, 8'hff);
        wait_ready();
        prog(SECI_OP_MISC, 8'h40, 64'h5a5a, 1, 1'b1);
        rd(8'hff, 80'h5a5a_5a5a, 2);
        u_seci_host.start(1'b1, 1'b0, SECI_OP_READ, 8'h00, d);
        u_seci_host.shift(16'h0000, 9, q);
        chk(q, 16'h01ff);
        u_seci_host.stop();
        cmd(1'b1, SECI_OP_MISC, 8'hc0);
        cmd(1'b1, SECI_OP_MISC, 8'h00);
        wait_ready();
        cmd(1'b1, SECI_OP_MISC, 8'hc0);
        cmd(1'b1, SECI_OP_WRITE, 8'h20);
        chk(progBusy, 1'b0);
        cmd(1'b0, SECI_OP_MISC, 8'h00);
        $display("t_fill done");
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        $display("Error t=%0t watchdog expired", $time);
        end_sim();
    end

    initial begin
        repeat (4) @(posedge mclk);
        #1;
        chk({progBusy, dataOutEn, writeEnabled}, 16'h0);
        resetn = 1'b1;
        u_seci_host.tick(4);
        t_locked();
        t_stream();
        t_bound();
        t_fill();
        end_sim();
    end
endmodule
